//--- pzm_pin_model.sv
// external circuitry at pin zero, driving the line while the block does not
`timescale 1ns/1ps
module pzm_pin_model (
  input logic pin_zero_o,
  input logic pin_zero_oe_o,
  input logic ext_val_i,
  output logic pin_zero_i
);
  // block drive wins, else the outside source sets the level
  assign pin_zero_i = pin_zero_oe_o ? pin_zero_o : ext_val_i;
endmodule

//--- pzm_pin_sync.sv
// two-flop synchroniser for the pin input level
`timescale 1ns/1ps
module pzm_pin_sync (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_q;
  logic meta_d;
  logic q_d;
  always_comb begin
    meta_d = d_i;
    q_d = meta_q;
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_q <= meta_d;
      q_o <= q_d;
    end
  end
endmodule

//--- pzm_pin_zero.sv
// mode control for general-purpose pin zero with its register port
//
// Overview of operation
// - the pin mode comes from bits 2:0 of the config register; bits 7:3 are reserved.
// - mode 000 makes the pin an input reported in bit 0 of the input-status register.
// - mode 001 drives the pin from bit 0 of the output-value register.
// - mode 010 lets the pin steer the host register bit picked by the selector.
// - in control mode the function follows any change of pin or selected bit.
// - in control mode the applied value is the OR of pin level and selected bit.
// - mode 011 drives the pin as a mirror of the selected host register bit.
// - the selector holds page 11:8, offset 6:0 and bit position 14:12.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module pzm_pin_zero (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [11:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic pin_zero_i,
  output logic pin_zero_o,
  output logic pin_zero_oe_o,
  output logic [3:0] host_page_o,
  output logic [6:0] host_offset_o,
  output logic [2:0] host_bitpos_o,
  input wire logic host_bit_i,
  output logic ctrl_active_o,
  output logic ctrl_value_o,
  output logic ctrl_update_o
);
  //////////////////////////////////////////////////////////////////////////////
  // address decode; one hit per mapped byte, a write enable for all but input status; a read and a write can share a cycle
  logic hit_sel_hi;
  logic hit_sel_lo;
  logic hit_cfg;
  logic hit_out;
  logic hit_in;
  logic we_sel_hi;
  logic we_sel_lo;
  logic we_cfg;
  logic we_out;

  always_comb begin
    // big-endian pair: the lower address holds the upper selector byte
    hit_sel_hi = addr_i == pzm_pkg::ADDR_SELECT_LO;
    hit_sel_lo = addr_i == pzm_pkg::ADDR_SELECT_HI;
    hit_cfg = addr_i == pzm_pkg::ADDR_CONFIG;
    hit_out = addr_i == pzm_pkg::ADDR_OUT_VALUE;
    hit_in = addr_i == pzm_pkg::ADDR_IN_STATUS;
    we_sel_hi = wr_i && hit_sel_hi;
    we_sel_lo = wr_i && hit_sel_lo;
    we_cfg = wr_i && hit_cfg;
    we_out = wr_i && hit_out;
  end

  //////////////////////////////////////////////////////////////////////////////
  // software registers; masks keep reserved bits at zero whatever is written
  logic [7:0] sel_lo_q;
  logic [7:0] sel_hi_q;
  logic [7:0] cfg_q;
  logic [7:0] out_q;

  // selector low byte carries the offset, reserved bit 7 masked
  pzm_reg8 #(
    .RESET_VAL(pzm_pkg::SELECT_RESET[7:0]),
    .WMASK(pzm_pkg::SELECT_LO_MASK)
  ) u_sel_lo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .we_i(we_sel_lo),
    .wdata_i(wdata_i),
    .q_o(sel_lo_q)
  );

  // selector high byte holds bit position and page, reserved bit 15 masked
  pzm_reg8 #(
    .RESET_VAL(pzm_pkg::SELECT_RESET[15:8]),
    .WMASK(pzm_pkg::SELECT_HI_MASK)
  ) u_sel_hi (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .we_i(we_sel_hi),
    .wdata_i(wdata_i),
    .q_o(sel_hi_q)
  );

  // only the mode field is stored; the reserved bits cannot hold a value
  pzm_reg8 #(
    .RESET_VAL(pzm_pkg::CONFIG_RESET),
    .WMASK(pzm_pkg::CONFIG_WMASK)
  ) u_cfg (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .we_i(we_cfg),
    .wdata_i(wdata_i),
    .q_o(cfg_q)
  );

  pzm_reg8 #(
    .RESET_VAL(pzm_pkg::OUT_RESET),
    .WMASK(pzm_pkg::OUT_WMASK)
  ) u_out (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .we_i(we_out),
    .wdata_i(wdata_i),
    .q_o(out_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pin level; two flops keep a slow outside edge from going metastable inside
  logic pin_s;

  pzm_pin_sync u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(pin_zero_i),
    .q_o(pin_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // selector fields out to the host register map
  always_comb begin
    host_offset_o = sel_lo_q[pzm_pkg::OFFSET_W-1:0];
    host_page_o = sel_hi_q[pzm_pkg::PAGE_W-1:0];
    host_bitpos_o = sel_hi_q[pzm_pkg::BITPOS_LSB+:pzm_pkg::BITPOS_W];
  end

  //////////////////////////////////////////////////////////////////////////////
  // mode decode; undefined codes fall back to input so the pad stays released
  logic [pzm_pkg::MODE_W-1:0] mode_field;
  pzm_pkg::pzm_mode_t mode;
  logic is_input;
  logic is_control;

  always_comb begin
    mode_field = cfg_q[pzm_pkg::MODE_W-1:0];
    case (mode_field)
      pzm_pkg::PZM_MODE_OUTPUT: mode = pzm_pkg::PZM_MODE_OUTPUT;
      pzm_pkg::PZM_MODE_CONTROL: mode = pzm_pkg::PZM_MODE_CONTROL;
      pzm_pkg::PZM_MODE_STATUS: mode = pzm_pkg::PZM_MODE_STATUS;
      default: mode = pzm_pkg::PZM_MODE_INPUT;
    endcase
  end

  always_comb begin
    is_input = mode == pzm_pkg::PZM_MODE_INPUT;
    is_control = mode == pzm_pkg::PZM_MODE_CONTROL;
  end

  //////////////////////////////////////////////////////////////////////////////
  // pad drive is registered so a mode change never glitches the pin
  logic pin_d;
  logic oe_d;
  logic pin_q;
  logic oe_q;

  always_comb begin
    pin_d = 1'b0;
    oe_d = 1'b0;
    case (mode)
      pzm_pkg::PZM_MODE_OUTPUT: begin
        pin_d = out_q[0];
        oe_d = 1'b1;
      end
      pzm_pkg::PZM_MODE_STATUS: begin
        pin_d = host_bit_i;
        oe_d = 1'b1;
      end
      default: begin
        // input and control leave the pin to the outside circuit
        pin_d = 1'b0;
        oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pin_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      oe_q <= oe_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // last seen level of both control sources, tracked in every mode
  logic host_d;
  logic host_q;
  logic pinl_d;
  logic pinl_q;

  always_comb begin
    host_d = host_bit_i;
    pinl_d = pin_s;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      host_q <= 1'b0;
      pinl_q <= 1'b0;
    end else begin
      host_q <= host_d;
      pinl_q <= pinl_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control path; a badly chosen target bit is not caught here, software owns that
  logic src_change;
  logic cact_d;
  logic cval_d;
  logic upd_d;
  logic cact_q;
  logic cval_q;
  logic upd_q;

  always_comb begin
    src_change = pin_s != pinl_q || host_bit_i != host_q;
    cact_d = 1'b0;
    cval_d = cval_q;
    upd_d = 1'b0;
    if (is_control) begin
      cact_d = 1'b1;
      cval_d = pin_s | host_bit_i;
      // entry to control counts as a change so the value is applied at once
      upd_d = !cact_q || src_change;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cact_q <= 1'b0;
      cval_q <= 1'b0;
      upd_q <= 1'b0;
    end else begin
      cact_q <= cact_d;
      cval_q <= cval_d;
      upd_q <= upd_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pad and control outputs straight from their flops
  always_comb begin
    pin_zero_o = pin_q;
    pin_zero_oe_o = oe_q;
    ctrl_active_o = cact_q;
    ctrl_value_o = cval_q;
    ctrl_update_o = upd_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port; unmapped addresses read zero
  logic in_status;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;

  always_comb begin
    // input level shown only in input mode, else held at zero
    in_status = pin_s & is_input;
  end

  always_comb begin
    rdata_d = 8'h00;
    if (rd_i) begin
      if (hit_sel_hi) begin
        rdata_d = sel_hi_q;
      end else if (hit_sel_lo) begin
        rdata_d = sel_lo_q;
      end else if (hit_cfg) begin
        rdata_d = cfg_q;
      end else if (hit_out) begin
        rdata_d = out_q;
      end else if (hit_in) begin
        rdata_d = {7'h00, in_status};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    rdata_o = rdata_q;
  end
endmodule

//--- pzm_pin_zero_monitor.sv
// checker of pin-zero mode block port behaviour
`timescale 1ns/1ps
module pzm_pin_zero_monitor (
  input logic clk_i,
  input logic rstn_i,
  input logic [11:0] addr_i,
  input logic [7:0] wdata_i,
  input logic wr_i,
  input logic rd_i,
  input logic [7:0] rdata_o,
  input logic pin_zero_i,
  input logic pin_zero_o,
  input logic pin_zero_oe_o,
  input logic [3:0] host_page_o,
  input logic [6:0] host_offset_o,
  input logic [2:0] host_bitpos_o,
  input logic host_bit_i,
  input logic ctrl_active_o,
  input logic ctrl_value_o,
  input logic ctrl_update_o
);
  logic [2:0] mode_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // shadow of the mode field, built from bus writes only
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mode_q <= 3'h0;
    end else if (wr_i && addr_i == pzm_pkg::ADDR_CONFIG) begin
      mode_q <= wdata_i[2:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_cfg_readback: assert property (
    $past(rd_i) && $past(addr_i) == pzm_pkg::ADDR_CONFIG |-> rdata_o == {5'h00, $past(mode_q)})
    else $error("config read wrong");
  a_out_drive: assert property ((mode_q == 3'h1)[*2] |-> pin_zero_oe_o)
    else $error("output mode not driving");
  a_hiz_modes: assert property (
    (mode_q != 3'h1 && mode_q != 3'h3)[*2] |-> !pin_zero_oe_o)
    else $error("pin driven in input mode");
  a_status_mirror: assert property (
    (mode_q == 3'h3)[*2] |-> pin_zero_oe_o && pin_zero_o == $past(host_bit_i))
    else $error("status pin not mirroring");
  a_ctrl_active: assert property ((mode_q == 3'h2)[*2] |-> ctrl_active_o)
    else $error("control mode not active");
  a_ctrl_or_low: assert property (
    (!pin_zero_i)[*3] ##0 (ctrl_active_o && !host_bit_i) ##1 ctrl_active_o |-> !ctrl_value_o)
    else $error("control value high with both sources low");
  a_host_update: assert property (
    ctrl_active_o && $changed(host_bit_i) ##1 ctrl_active_o
    |-> ctrl_update_o && ctrl_value_o == ($past(host_bit_i) | $past(pin_zero_i, 3)))
    else $error("no update on host bit change");
  a_sel_fields: assert property (
    $past(wr_i) && $past(addr_i) == pzm_pkg::ADDR_SELECT_LO
    |-> {host_bitpos_o, host_page_o} == $past(wdata_i[6:0]))
    else $error("selector fields wrong");
  a_offset_field: assert property (
    $past(wr_i) && $past(addr_i) == pzm_pkg::ADDR_SELECT_HI
    |-> host_offset_o == $past(wdata_i[6:0]))
    else $error("offset field wrong");
  c_update: cover property (ctrl_update_o);
  c_status: cover property (mode_q == 3'h3 && pin_zero_oe_o);
  c_read: cover property ($past(rd_i) && rdata_o != 8'h00);
endmodule
bind pzm_pin_zero pzm_pin_zero_monitor u_pzm_pin_zero_monitor (.clk_i, .rstn_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_zero_i, .pin_zero_o, .pin_zero_oe_o, .host_page_o,
  .host_offset_o, .host_bitpos_o, .host_bit_i, .ctrl_active_o, .ctrl_value_o, .ctrl_update_o);

//--- pzm_pin_zero_tb.sv
// self-checking bench of the pin-zero mode block
`timescale 1ns/1ps
module pzm_pin_zero_tb;
  logic clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, host_bit_i = 1'b0, ext = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [7:0] wdata_i = 8'h00, rdata_o, r;
  logic pin_zero_i, pin_zero_o, pin_zero_oe_o, ctrl_active_o, ctrl_value_o, ctrl_update_o;
  logic [3:0] host_page_o;
  logic [6:0] host_offset_o;
  logic [2:0] host_bitpos_o;
  int failures = 0, checks = 0, seed = 32'h7531;
  always #4 clk_i = ~clk_i;
  pzm_pin_zero u_pzm_pin_zero (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .pin_zero_i, .pin_zero_o, .pin_zero_oe_o, .host_page_o, .host_offset_o, .host_bitpos_o,
    .host_bit_i, .ctrl_active_o, .ctrl_value_o, .ctrl_update_o);
  pzm_pin_model u_pzm_pin_model (.pin_zero_o, .pin_zero_oe_o, .ext_val_i(ext), .pin_zero_i);
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // each access leaves one idle cycle so no strobe is assigned twice in a step
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk("rdata", e, rdata_o);
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(pzm_pkg::ADDR_CONFIG, 8'h00);
    rd(12'h123, 8'h00);
    wr(pzm_pkg::ADDR_CONFIG, 8'hFF);
    rd(pzm_pkg::ADDR_CONFIG, 8'h07);
    @(posedge clk_i);
    ext <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      wr(pzm_pkg::ADDR_CONFIG, 8'(m));
      repeat (3) @(negedge clk_i);
      chk("oe", 8'(m == 1 || m == 3), 8'(pin_zero_oe_o));
      rd(pzm_pkg::ADDR_IN_STATUS, {7'h00, m == 0 || m > 3});
    end
    for (int i = 0; i < 16; i++) begin
      r = 8'($random(seed));
      wr(pzm_pkg::ADDR_CONFIG, 8'h00);
      wr(pzm_pkg::ADDR_OUT_VALUE, r);
      wr(pzm_pkg::ADDR_SELECT_LO, r);
      wr(pzm_pkg::ADDR_SELECT_HI, r);
      @(posedge clk_i);
      ext <= r[7];
      host_bit_i <= r[1];
      repeat (4) @(negedge clk_i);
      chk("sel", 8'(r[6:0]), 8'({host_bitpos_o, host_page_o}));
      chk("offset", 8'(r[6:0]), 8'(host_offset_o));
      rd(pzm_pkg::ADDR_SELECT_LO, {1'b0, r[6:0]});
      rd(pzm_pkg::ADDR_SELECT_HI, {1'b0, r[6:0]});
      rd(pzm_pkg::ADDR_OUT_VALUE, {7'h00, r[0]});
      rd(pzm_pkg::ADDR_IN_STATUS, {7'h00, r[7]});
      wr(pzm_pkg::ADDR_CONFIG, 8'h02);
      repeat (3) @(negedge clk_i);
      chk("ctrl", {6'h00, 1'b1, r[7] | r[1]}, {6'h00, ctrl_active_o, ctrl_value_o});
      rd(pzm_pkg::ADDR_IN_STATUS, 8'h00);
      @(posedge clk_i);
      host_bit_i <= ~r[1];
      repeat (2) @(negedge clk_i);
      chk("ctrl2", {7'h00, r[7] | ~r[1]}, 8'(ctrl_value_o));
      chk("update", 8'h01, 8'(ctrl_update_o));
      wr(pzm_pkg::ADDR_CONFIG, {r[6:2], 3'h3});
      repeat (3) @(negedge clk_i);
      chk("status", {7'h00, ~r[1]}, 8'(pin_zero_o));
      wr(pzm_pkg::ADDR_CONFIG, 8'h01);
      repeat (3) @(negedge clk_i);
      chk("out", {7'h00, r[0]}, 8'(pin_zero_o));
    end
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(pzm_pkg::ADDR_CONFIG, 8'h00);
    conclude();
  end
endmodule

//--- pzm_pkg.sv
// package of register map and mode constants for the pin-zero mode block
package pzm_pkg;
  localparam logic [11:0] ADDR_SELECT_LO = 12'h0E0;
  localparam logic [11:0] ADDR_SELECT_HI = 12'h0E1;
  localparam logic [11:0] ADDR_CONFIG = 12'h0E2;
  localparam logic [11:0] ADDR_OUT_VALUE = 12'h0EF;
  localparam logic [11:0] ADDR_IN_STATUS = 12'h140;
  localparam int MODE_W = 3;
  localparam int OFFSET_W = 7;
  localparam int PAGE_W = 4;
  localparam int BITPOS_W = 3;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [15:0] SELECT_RESET = 16'h0000;
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic [7:0] SELECT_HI_MASK = 8'h7F;
  localparam logic [7:0] SELECT_LO_MASK = 8'h7F;
  localparam logic [7:0] CONFIG_WMASK = 8'h07;
  localparam logic [7:0] OUT_WMASK = 8'h01;
  localparam int BITPOS_LSB = 4;
  typedef enum logic [2:0] {
    PZM_MODE_INPUT = 3'h0,
    PZM_MODE_OUTPUT = 3'h1,
    PZM_MODE_CONTROL = 3'h2,
    PZM_MODE_STATUS = 3'h3
  } pzm_mode_t;
endpackage

//--- pzm_reg8.sv
// one software-written byte register with a writable-bit mask
`timescale 1ns/1ps
module pzm_reg8 #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] q_o
);
  logic [7:0] q_d;
  always_comb begin
    q_d = q_o;
    if (we_i) begin
      q_d = wdata_i & WMASK;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      q_o <= RESET_VAL;
    end else begin
      q_o <= q_d;
    end
  end
endmodule
